// >>> ebt_defines.svh
// Purpose: constants for the event break and trace block
// Assumes: apb byte addresses, 32-bit data
// Notes: condition codes are shared by break, start and stop selects
`ifndef EBT_DEFINES_SVH
`define EBT_DEFINES_SVH
`define EBT_A_CTRL 8'h00
`define EBT_A_EVA_ADDR 8'h04
`define EBT_A_EVA_CFG 8'h08
`define EBT_A_EVB_ADDR 8'h0c
`define EBT_A_EVB_CFG 8'h10
`define EBT_A_STATUS 8'h14
`define EBT_A_TR_PTR 8'h18
`define EBT_A_TR_LO 8'h1c
`define EBT_A_TR_HI 8'h20
`define EBT_C_NONE 3'h0
`define EBT_C_A 3'h1
`define EBT_C_AORB 3'h2
`define EBT_C_AANDB 3'h3
`define EBT_C_BTHENA 3'h4
`define EBT_C_FULL 3'h5
`define EBT_DIR_RW 2'h0
`define EBT_DIR_RD 2'h1
`define EBT_DIR_WR 2'h2
`define EBT_CTRL_RST 32'h0000_0000
`define EBT_CFG_RST 32'h0000_0000
`endif

// >>> ebt_pkg.sv
// Purpose: types for the event break and trace block
// Assumes: nothing
// Notes: capture states gray coded along idle-wait-trace-stop
package ebt_pkg;
  typedef enum logic [1:0] {
    EBT_IDLE = 2'b00,
    EBT_WAIT = 2'b01,
    EBT_TRACE = 2'b11,
    EBT_STOP = 2'b10
  } ebt_state_e;
  typedef logic [2:0] ebt_cond_t;
endpackage : ebt_pkg

// >>> ebt_core.sv
// Purpose: event compare, break and trace capture behind an apb slave
// Assumes: cpu bus and branch inputs synchronous to i_clk
// Notes: i_wdt_rst is a one-cycle synchronous watchdog reset pulse
`timescale 1ns/1ps
`include "ebt_defines.svh"
module ebt_core
  import ebt_pkg::*;
#(
  parameter int AW = 20,
  parameter int DW = 16,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_run,
  input wire logic i_wdt_rst,
  input wire logic i_bus_valid,
  input wire logic i_bus_write,
  input wire logic i_bus_dtc,
  input wire logic [AW-1:0] i_bus_addr,
  input wire logic [DW-1:0] i_bus_data,
  input wire logic i_branch_valid,
  input wire logic [AW-1:0] i_branch_src,
  input wire logic [AW-1:0] i_branch_dst,
  output logic o_break_req
);
  localparam int IW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULLCNT = CW'(DEPTH);

  logic [31:0] ctrl_reg;
  logic [31:0] ev_addr_reg [2];
  logic [31:0] ev_cfg_reg [2];
  logic [CW-1:0] ptr_reg;
  logic [CW-1:0] cnt_reg;
  logic [31:0] mem_lo [DEPTH];
  logic [31:0] mem_hi [DEPTH];
  logic [31:0] prdata_reg;
  logic brk_reg;
  logic run_q_reg;
  logic sa_reg;
  logic sb_reg;
  logic arm_reg;
  ebt_state_e st_reg;
  ebt_state_e st_next;
  logic [1:0] hit;
  logic wr_en;
  logic rd_setup;
  logic mapped;
  logic [31:0] rd_mux;
  logic run_rise;
  logic clr;
  logic full;
  logic start_now;
  logic stop_now;
  logic brk_cond;
  logic rec_hit;
  logic rec_en;
  logic fill_now;
  ebt_cond_t brk_sel;
  ebt_cond_t start_sel;
  ebt_cond_t stop_sel;

  assign brk_sel = ctrl_reg[2:0];
  assign start_sel = ctrl_reg[7:5];
  assign stop_sel = ctrl_reg[10:8];
  assign run_rise = i_run & ~run_q_reg;
  assign clr = run_rise | i_wdt_rst;
  assign full = (cnt_reg == FULLCNT);

  // apb slave: zero wait states, read data latched in setup
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~mapped;
  assign o_prdata = prdata_reg;
  assign wr_en = i_psel & i_penable & i_pwrite & mapped;
  assign rd_setup = i_psel & ~i_penable & ~i_pwrite;

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0;
    case (i_paddr)
      `EBT_A_CTRL: rd_mux = ctrl_reg;
      `EBT_A_EVA_ADDR: rd_mux = ev_addr_reg[0];
      `EBT_A_EVA_CFG: rd_mux = ev_cfg_reg[0];
      `EBT_A_EVB_ADDR: rd_mux = ev_addr_reg[1];
      `EBT_A_EVB_CFG: rd_mux = ev_cfg_reg[1];
      `EBT_A_STATUS: rd_mux = {16'h0, 8'(cnt_reg), 1'b0, brk_reg, full,
                              st_reg, arm_reg, sb_reg, sa_reg};
      `EBT_A_TR_PTR: rd_mux = 32'(ptr_reg);
      `EBT_A_TR_LO: rd_mux = (ptr_reg < cnt_reg) ? mem_lo[ptr_reg[IW-1:0]] : 32'h0;
      `EBT_A_TR_HI: rd_mux = (ptr_reg < cnt_reg) ? mem_hi[ptr_reg[IW-1:0]] : 32'h0;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prdata_reg <= 32'h0;
    end else if (rd_setup) begin
      prdata_reg <= rd_mux;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_reg <= `EBT_CTRL_RST;
      ptr_reg <= '0;
    end else if (wr_en) begin
      if (i_paddr == `EBT_A_CTRL) begin
        ctrl_reg <= {20'h0, i_pwdata[11:0]};
      end
      if (i_paddr == `EBT_A_TR_PTR) begin
        ptr_reg <= i_pwdata[CW-1:0];
      end
    end
  end

  // one address and one config word per channel; a write replaces it
  genvar g;
  for (g = 0; g < 2; g++) begin : g_ev
    logic [AW-1:0] mask;
    logic dir_ok;
    logic [7:0] wa_addr;
    logic [7:0] wa_cfg;
    assign wa_addr = (g == 0) ? `EBT_A_EVA_ADDR : `EBT_A_EVB_ADDR;
    assign wa_cfg = (g == 0) ? `EBT_A_EVA_CFG : `EBT_A_EVB_CFG;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        ev_addr_reg[g] <= 32'h0;
        ev_cfg_reg[g] <= `EBT_CFG_RST;
      end else if (wr_en) begin
        if (i_paddr == wa_addr) begin
          ev_addr_reg[g] <= {{(32-AW){1'b0}}, i_pwdata[AW-1:0]};
        end
        if (i_paddr == wa_cfg) begin
          ev_cfg_reg[g] <= {24'h0, i_pwdata[7:0]};
        end
      end
    end
    // mask of 1..15 low bits; zero count treated as unmasked
    assign mask = ev_cfg_reg[g][1] ? ~((AW'(1) << ev_cfg_reg[g][5:2]) - AW'(1))
                                   : {AW{1'b1}};
    always_comb begin
      case (ev_cfg_reg[g][7:6])
        `EBT_DIR_RW: dir_ok = 1'b1;
        `EBT_DIR_RD: dir_ok = ~i_bus_write;
        `EBT_DIR_WR: dir_ok = i_bus_write;
        default: dir_ok = 1'b0;
      endcase
    end
    assign hit[g] = ev_cfg_reg[g][0] & i_run & i_bus_valid & ~i_bus_dtc & dir_ok
      & (((i_bus_addr ^ ev_addr_reg[g][AW-1:0]) & mask) == '0);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run_q_reg <= 1'b0;
      sa_reg <= 1'b0;
      sb_reg <= 1'b0;
      arm_reg <= 1'b0;
    end else begin
      run_q_reg <= i_run;
      // fresh hits win over the run-start clear
      sa_reg <= (clr ? 1'b0 : sa_reg) | hit[0];
      sb_reg <= (clr ? 1'b0 : sb_reg) | hit[1];
      arm_reg <= (clr ? 1'b0 : arm_reg) | hit[1];
    end
  end

  function automatic logic cond_met(input ebt_cond_t sel, input logic [1:0] h,
                                    input logic a_s, input logic b_s,
                                    input logic arm, input logic fl);
    case (sel)
      `EBT_C_A: cond_met = h[0];
      `EBT_C_AORB: cond_met = |h;
      `EBT_C_AANDB: cond_met = (h[0] | a_s) & (h[1] | b_s) & (|h);
      `EBT_C_BTHENA: cond_met = arm & h[0];
      `EBT_C_FULL: cond_met = fl;
      default: cond_met = 1'b0;
    endcase
  endfunction : cond_met

  assign brk_cond = cond_met(brk_sel, hit, sa_reg & ~clr, sb_reg & ~clr,
                             arm_reg & ~clr, 1'b0);
  assign start_now = cond_met(start_sel, hit, sa_reg & ~clr, sb_reg & ~clr,
                              arm_reg & ~clr, 1'b0);
  assign stop_now = cond_met(stop_sel, hit, sa_reg & ~clr, sb_reg & ~clr,
                             arm_reg & ~clr, full) | ~i_run;

  assign rec_hit = ctrl_reg[11] ? (|hit) : hit[0];
  assign rec_en = (st_reg == EBT_TRACE) & i_run & ~full & ~i_wdt_rst
    & (ctrl_reg[4] ? rec_hit : i_branch_valid);
  assign fill_now = rec_en & (cnt_reg == FULLCNT - CW'(1));

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      EBT_IDLE: st_next = EBT_IDLE;
      EBT_WAIT: begin
        if (start_now) begin
          st_next = EBT_TRACE;
        end else if (!i_run) begin
          st_next = EBT_STOP;
        end
      end
      EBT_TRACE: begin
        if (stop_now && !(start_now && start_sel != `EBT_C_NONE)) begin
          st_next = EBT_STOP;
        end
      end
      EBT_STOP: st_next = EBT_STOP;
      default: st_next = EBT_IDLE;
    endcase
    if (run_rise || i_wdt_rst) begin
      st_next = (start_sel == `EBT_C_NONE) ? EBT_TRACE : EBT_WAIT;
      if (!i_run) begin
        st_next = EBT_IDLE;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg <= EBT_IDLE;
      cnt_reg <= '0;
    end else begin
      st_reg <= st_next;
      if (clr) begin
        cnt_reg <= '0;
      end else if (rec_en) begin
        cnt_reg <= cnt_reg + CW'(1);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (rec_en && !clr) begin
      mem_lo[cnt_reg[IW-1:0]] <= ctrl_reg[4]
        ? {1'b1, ~hit[0], i_bus_write, {(29-AW){1'b0}}, i_bus_addr}
        : {3'b000, {(29-AW){1'b0}}, i_branch_src};
      mem_hi[cnt_reg[IW-1:0]] <= ctrl_reg[4]
        ? {{(32-DW){1'b0}}, i_bus_data}
        : {{(32-AW){1'b0}}, i_branch_dst};
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      brk_reg <= 1'b0;
    end else begin
      brk_reg <= i_run & ~i_wdt_rst & (brk_cond | (ctrl_reg[3] & fill_now));
    end
  end
  assign o_break_req = brk_reg;

  sequence s_arm;
    brk_sel == `EBT_C_BTHENA && hit[1] && !clr;
  endsequence
  sequence s_fire;
    hit[0] && !clr && i_run;
  endsequence

  property p_none;
    @(posedge i_clk) disable iff (!i_rst_n)
      (brk_sel == `EBT_C_NONE && !ctrl_reg[3]) |=> !o_break_req;
  endproperty
  a_none: assert property (p_none) else $error("break without condition");
  property p_a;
    @(posedge i_clk) disable iff (!i_rst_n)
      (brk_sel == `EBT_C_A && hit[0] && !i_wdt_rst) |=> o_break_req;
  endproperty
  a_a: assert property (p_a) else $error("primary hit did not break");
  property p_or;
    @(posedge i_clk) disable iff (!i_rst_n)
      (brk_sel == `EBT_C_AORB && hit[1] && !i_wdt_rst) |=> o_break_req;
  endproperty
  a_or: assert property (p_or) else $error("secondary hit did not break");
  property p_and;
    @(posedge i_clk) disable iff (!i_rst_n)
      (brk_sel == `EBT_C_AANDB && hit == 2'b01 && !sb_reg && !ctrl_reg[3]) |=> !o_break_req;
  endproperty
  a_and: assert property (p_and) else $error("and break on one channel");
  property p_seq;
    @(posedge i_clk) disable iff (!i_rst_n)
      s_arm ##1 (s_fire and (brk_sel == `EBT_C_BTHENA) and !i_wdt_rst) |=> o_break_req;
  endproperty
  a_seq: assert property (p_seq) else $error("sequential break missed");
  property p_dtc;
    @(posedge i_clk) disable iff (!i_rst_n)
      i_bus_dtc |-> hit == 2'b00;
  endproperty
  a_dtc: assert property (p_dtc) else $error("controller access hit");
  property p_wdt;
    @(posedge i_clk) disable iff (!i_rst_n)
      i_wdt_rst |=> cnt_reg == '0 && !o_break_req;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog did not clear");
  property p_skip;
    @(posedge i_clk) disable iff (!i_rst_n)
      (st_reg == EBT_WAIT && !clr) |=> $stable(cnt_reg);
  endproperty
  a_skip: assert property (p_skip) else $error("recorded before start");
  property p_full;
    @(posedge i_clk) disable iff (!i_rst_n)
      (st_reg == EBT_TRACE && stop_sel == `EBT_C_FULL && full && start_sel == `EBT_C_NONE
       && !clr) |=> st_reg == EBT_STOP;
  endproperty
  a_full: assert property (p_full) else $error("full stop missed");
  property p_frz;
    @(posedge i_clk) disable iff (!i_rst_n)
      (st_reg == EBT_STOP && !clr) |=> $stable(cnt_reg) && st_reg == EBT_STOP;
  endproperty
  a_frz: assert property (p_frz) else $error("stopped buffer changed");
  property p_halt;
    @(posedge i_clk) disable iff (!i_rst_n)
      (st_reg == EBT_TRACE && !i_run && !clr) |=> st_reg == EBT_STOP;
  endproperty
  a_halt: assert property (p_halt) else $error("halt did not end capture");
  property p_go;
    @(posedge i_clk) disable iff (!i_rst_n)
      (run_rise && !i_wdt_rst && start_sel == `EBT_C_NONE)
        |=> st_reg == EBT_TRACE && cnt_reg == '0;
  endproperty
  a_go: assert property (p_go) else $error("capture not started at run");
  property p_wait;
    @(posedge i_clk) disable iff (!i_rst_n)
      (run_rise && start_sel != `EBT_C_NONE) |=> st_reg == EBT_WAIT;
  endproperty
  a_wait: assert property (p_wait) else $error("event start did not wait");
  property p_start;
    @(posedge i_clk) disable iff (!i_rst_n)
      (st_reg == EBT_WAIT && start_now && !clr) |=> st_reg == EBT_TRACE;
  endproperty
  a_start: assert property (p_start) else $error("start event missed");
  property p_same;
    @(posedge i_clk) disable iff (!i_rst_n)
      (st_reg == EBT_TRACE && stop_now && start_now && start_sel != `EBT_C_NONE && !clr)
        |=> st_reg == EBT_TRACE;
  endproperty
  a_same: assert property (p_same) else $error("stop not ignored on start");
  property p_stop;
    @(posedge i_clk) disable iff (!i_rst_n)
      (st_reg == EBT_TRACE && stop_now && !start_now && !clr) |=> st_reg == EBT_STOP;
  endproperty
  a_stop: assert property (p_stop) else $error("stop event missed");
  property p_cap;
    @(posedge i_clk) disable iff (!i_rst_n)
      cnt_reg <= FULLCNT;
  endproperty
  a_cap: assert property (p_cap) else $error("entry count beyond depth");
  property p_fbrk;
    @(posedge i_clk) disable iff (!i_rst_n)
      (ctrl_reg[3] && fill_now && !i_wdt_rst) |=> o_break_req;
  endproperty
  a_fbrk: assert property (p_fbrk) else $error("full break missed");
  property p_rec;
    @(posedge i_clk) disable iff (!i_rst_n)
      (rec_en && !clr) |=> cnt_reg == $past(cnt_reg) + CW'(1);
  endproperty
  a_rec: assert property (p_rec) else $error("entry not counted");
  property p_nodtc;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_bus_dtc && ctrl_reg[4] && !clr) |=> $stable(cnt_reg);
  endproperty
  a_nodtc: assert property (p_nodtc) else $error("controller access traced");
  property p_pick;
    @(posedge i_clk) disable iff (!i_rst_n)
      (ctrl_reg[4] && !ctrl_reg[11] && hit == 2'b10 && !clr) |=> $stable(cnt_reg);
  endproperty
  a_pick: assert property (p_pick) else $error("secondary hit recorded");
endmodule : ebt_core

// >>> ebt_cpu_model.sv
// Purpose: cpu data bus model driving the monitor port
// Assumes: one access per request cycle
// Notes: idle fields toggle so stale values never match
`timescale 1ns/1ps
module ebt_cpu_model (
  input wire logic i_clk,
  input wire logic i_req,
  input wire logic i_wr,
  input wire logic i_dtc,
  input wire logic [19:0] i_addr,
  output logic o_valid,
  output logic o_write,
  output logic o_dtc,
  output logic [19:0] o_addr,
  output logic [15:0] o_data
);
  initial begin
    o_valid = 1'b0;
    o_write = 1'b0;
    o_dtc = 1'b0;
    o_addr = 20'h0;
    o_data = 16'h0;
  end
  always @(posedge i_clk) begin
    o_valid <= i_req;
    o_write <= i_req ? i_wr : ~o_write;
    o_dtc <= i_req & i_dtc;
    o_addr <= i_req ? i_addr : ~o_addr;
    o_data <= i_req ? i_addr[15:0] : ~o_data;
  end
endmodule : ebt_cpu_model

// >>> event_break_trace_control_tb.sv
// Purpose: self-checking bench for ebt_core
// Assumes: zero wait apb, one cycle hit to break latency
// Notes: random accesses per break mode, corner cases for trace
`timescale 1ns/1ps
`include "ebt_defines.svh"
module event_break_trace_control_tb;
  logic i_clk = 0, i_rst_n = 0, psel = 0, pen = 0, pwr = 0, run = 0, wdt = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwd = 0, prd, rd;
  logic pready, perr, err, brk, req = 0, wr = 0, data_transfer_controller = 0, bv = 0, dd = 0;
  logic [3:0] lo = 0;
  logic [19:0] ad = 0, bs = 0, bd = 0, ma;
  logic mv, mw, md;
  logic [15:0] mdat;
  int n_fail = 0, n_tests = 0, cyc = 0;
  logic sa, sb, arm, a, b;
  always #12.5 i_clk = ~i_clk;
  ebt_cpu_model cpu (.i_clk(i_clk), .i_req(req), .i_wr(wr), .i_dtc(data_transfer_controller), .i_addr(ad),
    .o_valid(mv), .o_write(mw), .o_dtc(md), .o_addr(ma), .o_data(mdat));
  ebt_core uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwd), .o_prdata(prd), .o_pready(pready),
    .o_pslverr(perr), .i_run(run), .i_wdt_rst(wdt), .i_bus_valid(mv), .i_bus_write(mw),
    .i_bus_dtc(md), .i_bus_addr(ma), .i_bus_data(mdat), .i_branch_valid(bv),
    .i_branch_src(bs), .i_branch_dst(bd), .o_break_req(brk));
  task end_of_test;
    if (n_fail == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] ad_i, input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    paddr <= ad_i;
    pwd <= d;
    @(posedge i_clk);
    pen <= 1;
    do @(posedge i_clk); while (pready !== 1'b1);
    rd = prd;
    err = perr;
    psel <= 0;
    pen <= 0;
  endtask : apb
  function logic [7:0] cnt();
    return rd[15:8];
  endfunction : cnt
  function logic exp_brk(input logic [2:0] s);
    case (s)
      `EBT_C_A: return a;
      `EBT_C_AORB: return a | b;
      `EBT_C_AANDB: return (a | b) & (a | sa) & (b | sb);
      `EBT_C_BTHENA: return a & arm;
      default: return 1'b0;
    endcase
  endfunction : exp_brk
  task acc(input logic ch, input logic d, input logic w);
    @(posedge i_clk);
    req <= 1;
    data_transfer_controller <= d;
    wr <= w;
    ad <= (ch ? 20'h00200 : 20'h00100) | {16'h0, lo};
    @(posedge i_clk);
    req <= 0;
    @(posedge i_clk);
    #1;
  endtask : acc
  task restart;
    @(posedge i_clk);
    run <= 0;
    @(posedge i_clk);
    run <= 1;
    @(posedge i_clk);
    {sa, sb, arm} = 3'b000;
  endtask : restart
  initial begin
    void'($urandom(69));
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1;
    apb(0, `EBT_A_CTRL, 0);
    chk("ctrl_rst", `EBT_CTRL_RST, rd);
    apb(0, 8'h40, 0);
    chk("unmapped_err", 1, err);
    apb(1, `EBT_A_EVA_ADDR, 32'h100);
    apb(1, `EBT_A_EVB_ADDR, 32'h200);
    apb(1, `EBT_A_EVA_CFG, 1);
    apb(1, `EBT_A_EVB_CFG, 1);
    for (int s = 0; s < 5; s++) begin
      apb(1, `EBT_A_CTRL, s);
      restart();
      repeat (24) begin
        b = $urandom % 2;
        dd = ($urandom % 6) == 0;
        acc(b, dd, $urandom % 2);
        a = !b && !dd;
        b = b && !dd;
        chk("break", exp_brk(s[2:0]), brk);
        sa |= a;
        sb |= b;
        arm |= b;
      end
      // secondary hit, then primary hit on the very next cycle
      {sb, arm, a, b} = 4'b1110;
      @(posedge i_clk);
      req <= 1;
      data_transfer_controller <= 0;
      wr <= 0;
      ad <= 20'h00200;
      @(posedge i_clk);
      ad <= 20'h00100;
      @(posedge i_clk);
      req <= 0;
      @(posedge i_clk);
      #1;
      chk("pair_break", exp_brk(s[2:0]), brk);
    end
    apb(1, `EBT_A_CTRL, 1);
    lo = 4'hf;
    apb(1, `EBT_A_EVA_CFG, 32'h93);
    acc(0, 0, 1);
    chk("mask_write", 1, brk);
    acc(0, 0, 0);
    chk("dir_read", 0, brk);
    apb(1, `EBT_A_EVA_CFG, 32'h8f);
    acc(0, 0, 1);
    chk("mask_bits", 0, brk);
    lo = 4'h0;
    apb(1, `EBT_A_EVA_CFG, 1);
    apb(1, `EBT_A_CTRL, 0);
    restart();
    for (int i = 0; i < 20; i++) begin
      @(posedge i_clk);
      bv <= 1;
      bs <= 20'h10 + i;
      bd <= 20'h80 + i;
    end
    @(posedge i_clk);
    bv <= 0;
    apb(0, `EBT_A_STATUS, 0);
    chk("full_count", 16, cnt());
    chk("full_flag", 1, rd[5]);
    apb(1, `EBT_A_TR_PTR, 0);
    apb(0, `EBT_A_TR_LO, 0);
    chk("branch_src", 32'h10, rd);
    apb(0, `EBT_A_TR_HI, 0);
    chk("branch_dst", 32'h80, rd);
    @(posedge i_clk);
    wdt <= 1;
    @(posedge i_clk);
    wdt <= 0;
    apb(0, `EBT_A_STATUS, 0);
    chk("wdt_count", 0, cnt());
    apb(1, `EBT_A_CTRL, 32'h0000_0508);
    restart();
    for (int i = 0; i < 16; i++) begin
      @(posedge i_clk);
      bv <= 1;
      bs <= 20'h40 + 20'(i);
    end
    @(posedge i_clk);
    bv <= 0;
    #1;
    chk("full_break", 1, brk);
    apb(0, `EBT_A_STATUS, 0);
    chk("full_stop", 2'b10, rd[4:3]);
    for (int p = 0; p < 2; p++) begin
      apb(1, `EBT_A_CTRL, {p[0], 6'h0, 1'b1, 4'h0});
      restart();
      acc(0, 0, 0);
      acc(1, 0, 0);
      acc(0, 0, 1);
      acc(0, 1, 0);
      apb(0, `EBT_A_STATUS, 0);
      chk("pick_count", 2 + p, cnt());
    end
    apb(1, `EBT_A_TR_PTR, 1);
    apb(0, `EBT_A_TR_LO, 0);
    chk("data_entry", {3'b110, 9'h0, 20'h200}, rd);
    apb(1, `EBT_A_CTRL, 32'h0000_0b30);
    restart();
    acc(0, 0, 0);
    acc(0, 0, 0);
    apb(0, `EBT_A_STATUS, 0);
    chk("start_count", 1, cnt());
    chk("start_state", 2'b11, rd[4:3]);
    acc(1, 0, 0);
    apb(0, `EBT_A_STATUS, 0);
    chk("stop_state", 2'b10, rd[4:3]);
    apb(1, `EBT_A_CTRL, 32'h0000_0130);
    restart();
    acc(0, 0, 0);
    apb(0, `EBT_A_STATUS, 0);
    chk("same_cycle", 2'b11, rd[4:3]);
    @(posedge i_clk);
    run <= 0;
    apb(0, `EBT_A_STATUS, 0);
    chk("halt_state", 2'b10, rd[4:3]);
    end_of_test();
  end
endmodule : event_break_trace_control_tb
